// ---- common/idc_pkg.sv ----
// Functional notes
// - bit 7 set passes samples unchanged; clear applies the fs/2 sign alternation.
// - bit 6 set routes samples around the inverse sinc filter; clear inserts it.
// - bit 2 set skips the dc offset addition; there is no phase correction stage.
// - bit 1 clear gives high-side image; set gives inverted low-side image.
// - bit 0 set drops Q samples, gates Q clocks, copies I to both.
// - first stage mode bits 2:1; codes 00 and 01 leave input unmodulated.
// - first stage codes 10 and 11 modulate the input by its rate.
// - first stage control bit 0 set bypasses the first interpolation filter.
// - second stage mode bits 6:1; codes 000000 to 011011 are unmodulated.
// - second stage codes 100100 to 111111 modulate the input by its rate.
// - second stage control bit 0 set bypasses the second interpolation filter.
package idc_pkg;

    localparam int SAMPLE_W = 16;
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [ADDR_W-1:0] DP_CTRL_ADDR = 7'h1b;
    localparam logic [ADDR_W-1:0] FIRST_CTRL_ADDR = 7'h1c;
    localparam logic [ADDR_W-1:0] SECOND_CTRL_ADDR = 7'h1d;

    localparam logic [DATA_W-1:0] DP_CTRL_RST = 8'he4;
    localparam logic [DATA_W-1:0] FIRST_CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] SECOND_CTRL_RST = 8'h00;

    // implemented bits; the rest read as zero
    localparam logic [DATA_W-1:0] DP_CTRL_MASK = 8'he7;
    localparam logic [DATA_W-1:0] FIRST_CTRL_MASK = 8'h07;
    localparam logic [DATA_W-1:0] SECOND_CTRL_MASK = 8'h7f;

    localparam int DP_PREMOD_BYP = 7;
    localparam int DP_INVSINC_BYP = 6;
    localparam int DP_FIXED_ONE = 5;
    localparam int DP_PHASE_BYP = 2;
    localparam int DP_SIDEBAND = 1;
    localparam int DP_I_DUP = 0;

    localparam int FIRST_MODE_LSB = 1;
    localparam int FIRST_MODE_W = 2;
    localparam int FIRST_BYP = 0;
    localparam int SECOND_MODE_LSB = 1;
    localparam int SECOND_MODE_W = 6;
    localparam int SECOND_BYP = 0;
    localparam int SECOND_HALF_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // serial port framing: one instruction byte, one data byte, msb first
    localparam int SPI_RW_BIT = 7;
    localparam logic [2:0] SPI_LAST_BIT = 3'h7;

    typedef struct packed {
        logic [SAMPLE_W-1:0] i;
        logic [SAMPLE_W-1:0] q;
    } idc_sample_s;

    typedef struct packed {
        logic premod_bypass;
        logic invsinc_bypass;
        logic phase_bypass;
        logic low_sideband;
        logic i_duplicate_enable;
        logic [FIRST_MODE_W-1:0] first_stage_mode;
        logic first_stage_modulate;
        logic first_stage_bypass;
        logic [SECOND_MODE_W-1:0] second_stage_mode;
        logic second_stage_modulate;
        logic second_stage_mode_legal;
        logic second_stage_bypass;
    } idc_cfg_s;

    typedef enum logic [2:0] {
        SPI_IDLE,
        SPI_CMD,
        SPI_WR,
        SPI_RD,
        SPI_WAIT
    } idc_spi_e;

endpackage

// ---- rtl/idc_datapath_ctrl.sv ----
module idc_datapath_ctrl #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic spi_sclk_i,
    input wire logic spi_csn_i,
    input wire logic spi_sdio_i,
    output logic spi_sdio_o,
    output logic spi_sdio_oe_o,
    input wire logic sample_valid_i,
    input wire idc_pkg::idc_sample_s sample_i,
    output logic sample_ready_o,
    input wire idc_pkg::idc_sample_s dc_offset_i,
    output logic out_valid_o,
    output idc_pkg::idc_sample_s out_sample_o,
    input wire logic out_ready_i,
    output idc_pkg::idc_cfg_s cfg_o,
    output logic q_clk_en_o
);

    function automatic idc_pkg::idc_cfg_s decode_cfg(
        input logic [idc_pkg::DATA_W-1:0] dp,
        input logic [idc_pkg::DATA_W-1:0] first,
        input logic [idc_pkg::DATA_W-1:0] second
    );
        idc_pkg::idc_cfg_s c;
        logic [idc_pkg::SECOND_MODE_W-1:0] sm;
        c.premod_bypass = dp[idc_pkg::DP_PREMOD_BYP];
        c.invsinc_bypass = dp[idc_pkg::DP_INVSINC_BYP];
        c.phase_bypass = dp[idc_pkg::DP_PHASE_BYP];
        c.low_sideband = dp[idc_pkg::DP_SIDEBAND];
        c.i_duplicate_enable = dp[idc_pkg::DP_I_DUP];
        c.first_stage_mode = first[idc_pkg::FIRST_MODE_LSB +: idc_pkg::FIRST_MODE_W];
        c.first_stage_modulate = c.first_stage_mode[idc_pkg::FIRST_MODE_W-1];
        c.first_stage_bypass = first[idc_pkg::FIRST_BYP];
        sm = second[idc_pkg::SECOND_MODE_LSB +: idc_pkg::SECOND_MODE_W];
        c.second_stage_mode = sm;
        c.second_stage_modulate = sm[idc_pkg::SECOND_MODE_W-1];
        // only codes with equal halves name a passband
        c.second_stage_mode_legal = (sm[idc_pkg::SECOND_MODE_W-1 -: idc_pkg::SECOND_HALF_W] ==
                                     sm[idc_pkg::SECOND_HALF_W-1:0]);
        c.second_stage_bypass = second[idc_pkg::SECOND_BYP];
        return c;
    endfunction

    localparam idc_pkg::idc_cfg_s CFG_RST = decode_cfg(idc_pkg::DP_CTRL_RST, idc_pkg::FIRST_CTRL_RST,
                                                        idc_pkg::SECOND_CTRL_RST);

    ////////////////////////////////////////////////////////////////////////////
    // serial port pins into the clock domain
    logic [2:0] sclk_s_q;
    logic [2:0] csn_s_q;
    logic [2:0] sdio_s_q;

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_s_q <= 3'h0;
            csn_s_q <= 3'h7;
            sdio_s_q <= 3'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], spi_sclk_i};
            csn_s_q <= {csn_s_q[1:0], spi_csn_i};
            sdio_s_q <= {sdio_s_q[1:0], spi_sdio_i};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic [idc_pkg::DATA_W-1:0] shift_next;

    assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
    assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // serial port state machine
    idc_pkg::idc_spi_e spi_state_q;
    logic [2:0] bit_cnt_q;
    logic [idc_pkg::DATA_W-1:0] shift_q;
    logic [idc_pkg::DATA_W-1:0] rd_shift_q;
    logic [idc_pkg::DATA_W-1:0] rd_value;
    logic [idc_pkg::ADDR_W-1:0] addr_q;
    logic [idc_pkg::DATA_W-1:0] wr_data_q;
    logic wr_en_q;
    logic [idc_pkg::DATA_W-1:0] dp_ctrl_q;
    logic [idc_pkg::DATA_W-1:0] first_ctrl_q;
    logic [idc_pkg::DATA_W-1:0] second_ctrl_q;

    assign shift_next = {shift_q[idc_pkg::DATA_W-2:0], sdio_s_q[1]};

    always_comb begin
        rd_value = 8'h00;
        if (shift_next[idc_pkg::ADDR_W-1:0] == idc_pkg::DP_CTRL_ADDR) begin
            rd_value = dp_ctrl_q;
        end else if (shift_next[idc_pkg::ADDR_W-1:0] == idc_pkg::FIRST_CTRL_ADDR) begin
            rd_value = first_ctrl_q;
        end else if (shift_next[idc_pkg::ADDR_W-1:0] == idc_pkg::SECOND_CTRL_ADDR) begin
            rd_value = second_ctrl_q;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            spi_state_q <= idc_pkg::SPI_IDLE;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            rd_shift_q <= 8'h00;
            addr_q <= 7'h00;
            wr_data_q <= 8'h00;
            wr_en_q <= 1'b0;
            spi_sdio_o <= 1'b0;
            spi_sdio_oe_o <= 1'b0;
        end else begin
            wr_en_q <= 1'b0;
            if (csn_s_q[1]) begin
                spi_state_q <= idc_pkg::SPI_IDLE;
                spi_sdio_oe_o <= 1'b0;
            end else begin
                unique case (spi_state_q)
                    idc_pkg::SPI_IDLE: begin
                        spi_state_q <= idc_pkg::SPI_CMD;
                        bit_cnt_q <= 3'h0;
                    end
                    idc_pkg::SPI_CMD: begin
                        if (sclk_rise) begin
                            shift_q <= shift_next;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == idc_pkg::SPI_LAST_BIT) begin
                                addr_q <= shift_next[idc_pkg::ADDR_W-1:0];
                                rd_shift_q <= rd_value;
                                spi_state_q <= shift_next[idc_pkg::SPI_RW_BIT] ? idc_pkg::SPI_RD : idc_pkg::SPI_WR;
                            end
                        end
                    end
                    idc_pkg::SPI_WR: begin
                        if (sclk_rise) begin
                            shift_q <= shift_next;
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == idc_pkg::SPI_LAST_BIT) begin
                                wr_data_q <= shift_next;
                                wr_en_q <= 1'b1;
                                spi_state_q <= idc_pkg::SPI_WAIT;
                            end
                        end
                    end
                    idc_pkg::SPI_RD: begin
                        if (sclk_fall) begin
                            spi_sdio_oe_o <= 1'b1;
                            spi_sdio_o <= rd_shift_q[idc_pkg::DATA_W-1];
                            rd_shift_q <= {rd_shift_q[idc_pkg::DATA_W-2:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 3'h1;
                            if (bit_cnt_q == idc_pkg::SPI_LAST_BIT) begin
                                spi_state_q <= idc_pkg::SPI_WAIT;
                            end
                        end
                    end
                    idc_pkg::SPI_WAIT: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dp_ctrl_q <= idc_pkg::DP_CTRL_RST;
            first_ctrl_q <= idc_pkg::FIRST_CTRL_RST;
            second_ctrl_q <= idc_pkg::SECOND_CTRL_RST;
        end else if (wr_en_q) begin
            if (addr_q == idc_pkg::DP_CTRL_ADDR) begin
                dp_ctrl_q <= wr_data_q & idc_pkg::DP_CTRL_MASK;
            end
            if (addr_q == idc_pkg::FIRST_CTRL_ADDR) begin
                first_ctrl_q <= wr_data_q & idc_pkg::FIRST_CTRL_MASK;
            end
            if (addr_q == idc_pkg::SECOND_CTRL_ADDR) begin
                second_ctrl_q <= wr_data_q & idc_pkg::SECOND_CTRL_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample buffer
    logic buf_valid;
    logic adv;
    logic load;
    idc_pkg::idc_sample_s buf_data;

    assign adv = !out_valid_o || out_ready_i;
    assign load = adv && buf_valid;

    idc_skid_buf #(
        .WIDTH($bits(idc_pkg::idc_sample_s)),
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .in_valid_i(sample_valid_i),
        .in_data_i(sample_i),
        .in_ready_o(sample_ready_o),
        .out_valid_o(buf_valid),
        .out_data_o(buf_data),
        .out_ready_i(adv)
    );

    ////////////////////////////////////////////////////////////////////////////
    // active settings, swapped only when the output stage advances
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_o <= CFG_RST;
            q_clk_en_o <= 1'b1;
        end else if (adv) begin
            // whole settings at a sample boundary
            cfg_o <= decode_cfg(dp_ctrl_q, first_ctrl_q, second_ctrl_q);
            q_clk_en_o <= !dp_ctrl_q[idc_pkg::DP_I_DUP];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sample processing
    logic phase_q;
    logic [idc_pkg::SAMPLE_W-1:0] i_v;
    logic [idc_pkg::SAMPLE_W-1:0] q_v;

    always_comb begin
        i_v = buf_data.i;
        q_v = buf_data.q;
        if (!cfg_o.premod_bypass && phase_q) begin
            i_v = -i_v;
            q_v = -q_v;
        end
        if (!cfg_o.phase_bypass) begin
            i_v = i_v + dc_offset_i.i;
            q_v = q_v + dc_offset_i.q;
        end
        if (cfg_o.low_sideband) begin
            q_v = -q_v;
        end
        // incoming Q dropped, I on both
        if (cfg_o.i_duplicate_enable) begin
            q_v = i_v;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_valid_o <= 1'b0;
            out_sample_o <= '0;
            phase_q <= 1'b0;
        end else if (adv) begin
            out_valid_o <= buf_valid;
            if (buf_valid) begin
                out_sample_o <= '{i: i_v, q: q_v};
                phase_q <= !phase_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    sequence dp_write_s;
        wr_en_q && (addr_q == idc_pkg::DP_CTRL_ADDR) ##1 adv;
    endsequence

    premod_pass_a: assert property (
        (load && cfg_o.premod_bypass && cfg_o.phase_bypass) |=> (out_sample_o.i == $past(buf_data.i)))
        else $error("premodulator bypass altered the I sample");

    premod_flip_a: assert property (
        (load && !cfg_o.premod_bypass && cfg_o.phase_bypass && phase_q)
        |=> (out_sample_o.i == idc_pkg::SAMPLE_W'(-$past(buf_data.i))))
        else $error("premodulator did not invert an odd sample");

    invsinc_route_a: assert property (
        dp_write_s |=> (cfg_o.invsinc_bypass == $past(dp_ctrl_q[idc_pkg::DP_INVSINC_BYP])))
        else $error("inverse sinc routing does not follow its bit");

    offset_add_a: assert property (
        (load && cfg_o.premod_bypass && !cfg_o.phase_bypass)
        |=> (out_sample_o.i == idc_pkg::SAMPLE_W'($past(buf_data.i) + $past(dc_offset_i.i))))
        else $error("dc offset not added to I");

    sideband_low_a: assert property (
        (load && cfg_o.premod_bypass && cfg_o.phase_bypass && cfg_o.low_sideband && !cfg_o.i_duplicate_enable)
        |=> (out_sample_o.q == idc_pkg::SAMPLE_W'(-$past(buf_data.q))))
        else $error("low-side image did not invert Q");

    dup_copy_a: assert property (
        (load && cfg_o.i_duplicate_enable) |=> (out_sample_o.q == out_sample_o.i) && !q_clk_en_o)
        else $error("I duplication left Q data or Q clocks active");

    first_stage_a: assert property (
        adv |=> (cfg_o.first_stage_mode == $past(first_ctrl_q[2:1]))
            && (cfg_o.first_stage_modulate == $past(first_ctrl_q[2]))
            && (cfg_o.first_stage_bypass == $past(first_ctrl_q[0])))
        else $error("first stage settings not taken");

    second_stage_a: assert property (
        adv |=> (cfg_o.second_stage_mode == $past(second_ctrl_q[6:1]))
            && (cfg_o.second_stage_modulate == $past(second_ctrl_q[6]))
            && (cfg_o.second_stage_bypass == $past(second_ctrl_q[0])))
        else $error("second stage settings not taken");

    cfg_steady_a: assert property (
        !adv |=> $stable(cfg_o))
        else $error("settings changed while a sample was held");

endmodule // idc_datapath_ctrl

// ---- rtl/idc_skid_buf.sv ----
module idc_skid_buf #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_check
        $error("idc_skid_buf: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] count_q;
    logic [PTR_W:0] count_d;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_valid_o = (count_q != '0);
    assign out_data_o = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            // registered ready: full stalls the source one cycle ahead
            in_ready_o <= (count_d < (PTR_W+1)'(DEPTH));
        end
    end

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    buf_capacity_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        count_q <= (PTR_W+1)'(DEPTH))
        else $error("buffer holds more words than its depth");

    buf_hold_a: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (out_valid_o && !out_ready_i) |=> (out_valid_o && $stable(out_data_o)))
        else $error("buffer head changed while stalled");

endmodule // idc_skid_buf

// ---- test/idc_src_model.sv ----
module idc_src_model #(
    parameter logic [31:0] SEED = 32'h1f2e3d4c
) (
    input wire logic clock_i,
    input wire logic enable_i,
    input wire logic ready_i,
    output logic valid_o,
    output idc_pkg::idc_sample_s data_o
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [31:0] seed = SEED;
    logic taken;

    initial begin
        valid_o = 1'b0;
        data_o = '0;
    end

    // offer words with random gaps, hold each word until taken
    always @(posedge clock_i) begin
        taken = valid_o && ready_i;
        #1;
        if (!valid_o || taken) begin
            if (enable_i && ($random(seed) & 3) != 0) begin
                valid_o = 1'b1;
                data_o = $random(seed);
            end else begin
                // idle bus inverts the stale word every cycle
                valid_o = 1'b0;
                data_o = ~data_o;
            end
        end
    end
endmodule // idc_src_model

// ---- test/interpolation_datapath_control_tb.sv ----
module interpolation_datapath_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sclk = 1'b0;
    logic csn = 1'b1;
    logic sdio_tb = 1'b0;
    logic sdio_o, sdio_oe, sdio_w, sample_ready, out_valid, q_clk_en, src_valid, src_en, stall;
    logic out_ready = 1'b0;
    idc_pkg::idc_sample_s src_data, off, out_sample, e;
    idc_pkg::idc_cfg_s cfg;
    idc_pkg::idc_sample_s inq[$];
    logic [7:0] dp, rv;
    logic ph;
    logic [31:0] seed = 32'h76c793e9;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;

    always #2 clock_i = ~clock_i;
    // two-way pin resolved from both drivers
    assign sdio_w = sdio_oe ? sdio_o : sdio_tb;

    idc_src_model idc_src_model_i (.clock_i(clock_i), .enable_i(src_en), .ready_i(sample_ready),
        .valid_o(src_valid), .data_o(src_data));

    idc_datapath_ctrl idc_datapath_ctrl_i (.clock_i(clock_i), .rstn_i(rstn_i), .spi_sclk_i(sclk),
        .spi_csn_i(csn), .spi_sdio_i(sdio_w), .spi_sdio_o(sdio_o), .spi_sdio_oe_o(sdio_oe),
        .sample_valid_i(src_valid), .sample_i(src_data), .sample_ready_o(sample_ready),
        .dc_offset_i(off), .out_valid_o(out_valid), .out_sample_o(out_sample), .out_ready_i(out_ready),
        .cfg_o(cfg), .q_clk_en_o(q_clk_en));

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic spi(input logic [15:0] w, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        csn = 1'b0;
        for (int k = 0; k < nb; k++) begin
            sdio_tb = w[15-k];
            tick(4);
            sclk = 1'b1;
            tick(4);
            if (k >= 8) rd = {rd[6:0], sdio_w};
            sclk = 1'b0;
        end
        tick(4);
        csn = 1'b1;
        sdio_tb = ~sdio_tb;
        tick(8);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        spi({1'b0, a, d}, 16, x);
    endtask

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        spi({1'b1, a, 8'hff}, 16, d);
    endtask

    function automatic idc_pkg::idc_sample_s model(idc_pkg::idc_sample_s s);
        idc_pkg::idc_sample_s r;
        r = s;
        if (!dp[7] && ph) begin
            r.i = -r.i;
            r.q = -r.q;
        end
        if (!dp[2]) begin
            r.i = r.i + off.i;
            r.q = r.q + off.q;
        end
        if (dp[1]) r.q = -r.q;
        if (dp[0]) r.q = r.i;
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bench model follows every taken word to its output
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            num_errors++;
            complete_run();
        end else if (rstn_i) begin
            if (src_valid && sample_ready) inq.push_back(src_data);
            if (out_valid && out_ready) begin
                if (inq.size() == 0) begin
                    chk(32'h1, 32'h0);
                end else begin
                    e = model(inq.pop_front());
                    chk(out_sample, e);
                    ph = ~ph;
                end
            end
        end
    end

    always @(posedge clock_i) begin
        #1;
        out_ready = stall ? 1'b0 : (($random(seed) & 3) != 0);
    end

    task automatic run_stream();
        int k;
        src_en = 1'b1;
        tick(30);
        src_en = 1'b0;
        k = 0;
        while ((inq.size() != 0 || src_valid || out_valid) && k < 300) begin
            tick(1);
            k++;
        end
        chk(inq.size(), 0);
    endtask

    initial begin
        src_en = 1'b0;
        stall = 1'b0;
        off = '0;
        dp = idc_pkg::DP_CTRL_RST;
        ph = 1'b0;
        tick(20);
        rstn_i = 1'b1;
        tick(4);
        rd(7'h1b, rv);
        chk(rv, 8'he4);
        chk(sdio_oe, 1'b0);
        rd(7'h1c, rv);
        chk(rv, 8'h00);
        rd(7'h1d, rv);
        chk(rv, 8'h00);
        chk({cfg.premod_bypass, cfg.invsinc_bypass, cfg.phase_bypass, q_clk_en}, 4'hf);
        wr(7'h20, 8'h5a);
        rd(7'h20, rv);
        chk(rv, 8'h00);
        spi({1'b0, 7'h1c, 8'h07}, 12, rv);
        rd(7'h1c, rv);
        chk(rv, 8'h00);
        for (int c = 0; c < 8; c++) begin
            wr(7'h1c, {5'($random(seed)), 3'(c)});
            rd(7'h1c, rv);
            chk(rv, 8'(c));
            chk(cfg.first_stage_mode, c >> 1);
            chk(cfg.first_stage_modulate, (c >> 2) & 1);
            chk(cfg.first_stage_bypass, c & 1);
        end
        for (int c = 0; c < 9; c++) begin
            rv = (c == 8) ? 8'h02 : {1'b0, 3'(c), 3'(c), 1'(c)};
            wr(7'h1d, rv | {1'($random(seed)), 7'h00});
            chk(cfg.second_stage_mode, rv[6:1]);
            chk(cfg.second_stage_modulate, rv[6]);
            chk(cfg.second_stage_mode_legal, c != 8);
            chk(cfg.second_stage_bypass, rv[0]);
            rd(7'h1d, rv);
            chk(rv[7], 1'b0);
        end
        for (int c = 0; c < 16; c++) begin
            dp = {c[3], 1'($random(seed)), 1'b1, 2'b00, c[2:0]};
            off = $random(seed);
            wr(7'h1b, dp);
            rd(7'h1b, rv);
            chk(rv, dp);
            chk({cfg.premod_bypass, cfg.invsinc_bypass, cfg.phase_bypass}, {dp[7:6], dp[2]});
            chk({cfg.low_sideband, cfg.i_duplicate_enable, q_clk_en}, {dp[1:0], ~dp[0]});
            run_stream();
        end
        stall = 1'b1;
        src_en = 1'b1;
        tick(12);
        chk(sample_ready, 1'b0);
        stall = 1'b0;
        run_stream();
        complete_run();
    end
endmodule // interpolation_datapath_control_tb
